//--- verilog/stby_pkg.sv
package stby_pkg;

	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		st_reset = 3'h0,
		st_run = 3'h1,
		st_halt = 3'h2,
		st_idle = 3'h3,
		st_stop = 3'h4,
		st_settle = 3'h5
	} state_t;

	// ----------------------------------------
	// standby selection and clock source
	// ----------------------------------------
	typedef enum logic [1:0] {
		sel_halt = 2'h0,
		sel_idle = 2'h1,
		sel_stop = 2'h2
	} standby_sel_t;

	typedef enum logic [1:0] {
		src_resonator = 2'h0,
		src_ext_pll = 2'h1,
		src_direct = 2'h2
	} clk_src_t;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int FETCH_DELAY_CYCLES = 30;
	localparam int FETCH_CNT_W = 5;
	// settling is closed by the shortest watchdog time-out
	localparam int SETTLE_TIME_NS = 10500000;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CNT_W = 19;

endpackage : stby_pkg

//--- verilog/reset_pin_sync.sv
`timescale 1ns/1ps
module reset_pin_sync (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// pin and synchronised level
	input wire logic reset_pin_n,
	output logic reset_sync_n
);

	logic stage1_n;

	// first stage feeds only the second
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			stage1_n <= 1'b0;
			reset_sync_n <= 1'b0;
		end else begin
			stage1_n <= reset_pin_n;
			reset_sync_n <= stage1_n;
		end
	end

endmodule : reset_pin_sync

//--- verilog/settle_timer.sv
`timescale 1ns/1ps
module settle_timer #(
	parameter int WIDTH = 19,
	parameter int COUNT = 262500
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// control
	input wire logic start,
	input wire logic run,
	// status
	output logic done
);

	logic [WIDTH-1:0] count;

	// restarts from zero on every start
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
		end else if (start) begin
			count <= '0;
		end else if (run && !done) begin
			count <= count + 1'b1;
		end
	end

	assign done = (count >= WIDTH'(COUNT - 1));

endmodule : settle_timer

//--- verilog/standby_reset_control.sv
`timescale 1ns/1ps
// Function
// - stop mode halts oscillator and pll, all clocks cease
// - pll mode stop: pll stops with oscillator; settle before clocks resume
// - direct mode stop release resumes clocks with no lock-up wait
// - halt stops cpu clock; idle stops cpu and peripheral; stop stops all
// - cpu stopped in all standby; peripherals and hold work only in halt
// - all internal state kept through halt, idle and stop
// - halt: dram strobes high except cbr refresh; idle/stop: self-refresh
// - clock output keeps toggling in halt and idle unless disabled, then high; always high in stop
// - low reset input resets the whole device
// - reset rising starts program execution
// - output pins held in reset state throughout reset
// - after 30 reset cycles and no hold request, start instruction fetch
// - hold request is granted even during reset, same pin behaviour
// - clock output keeps toggling during reset
// - halt instruction enters standby; selection input picks the mode
// - idle release resumes at once without settling
// - after stop release in resonator or pll mode watchdog restarts at zero; time-out ends settling
module standby_reset_control #(
	parameter int SETTLE_CYCLES = stby_pkg::SETTLE_CYCLES
) (
	// clock and power-on reset
	input wire logic sys_clk,
	input wire logic nrst,
	// device reset pin
	input wire logic reset_pin_n,
	// cpu side
	input wire logic halt_exec,
	input wire logic [1:0] standby_sel,
	input wire logic [1:0] clk_source,
	input wire logic wake_request,
	input wire logic system_clock_output_disable,
	output logic system_reset,
	output logic fetch_start,
	output logic cpu_running,
	// clock gating
	output logic osc_enable,
	output logic pll_enable,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic io_retain,
	output logic system_clock_output,
	// bus hold
	input wire logic bus_hold_request_n,
	output logic bus_hold_grant_n,
	output logic bus_float,
	// dram strobes from the controller
	input wire logic ctl_ras_n,
	input wire logic ctl_dram_lower_column_strobe_n,
	input wire logic ctl_dram_upper_column_strobe_n,
	input wire logic ctl_dram_refresh_request_n,
	input wire logic cbr_active,
	// dram pins
	output logic dram_ras_n,
	output logic dram_lower_column_strobe_n,
	output logic dram_upper_column_strobe_n,
	output logic dram_refresh_request_n,
	output logic self_refresh,
	// watchdog
	input wire logic wdt_timeout_in,
	output logic wdt_clear,
	output logic watchdog_timeout_out
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	stby_pkg::state_t state;
	stby_pkg::state_t next_state;
	logic reset_sync_n;
	logic [stby_pkg::FETCH_CNT_W-1:0] fetch_cnt;
	logic fetch_ready;
	logic direct_mode;
	logic external_clk;
	logic standby;
	logic settle_start;
	logic settle_done;
	logic system_clock_output_q;

	function automatic logic strobe_idle(input stby_pkg::state_t s);
		strobe_idle = (s == stby_pkg::st_reset) || (s == stby_pkg::st_halt);
	endfunction : strobe_idle

	// ----------------------------------------
	// reset input path
	// ----------------------------------------
	// synchronise reset pin
	reset_pin_sync u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.reset_pin_n(reset_pin_n),
		.reset_sync_n(reset_sync_n)
	);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fetch_cnt <= '0;
		end else if (state != stby_pkg::st_reset) begin
			fetch_cnt <= '0;
		end else if (!fetch_ready) begin
			fetch_cnt <= fetch_cnt + 1'b1;
		end
	end

	assign fetch_ready = (fetch_cnt == stby_pkg::FETCH_CNT_W'(stby_pkg::FETCH_DELAY_CYCLES));
	assign direct_mode = (clk_source == stby_pkg::src_direct);
	assign external_clk = (clk_source != stby_pkg::src_resonator);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			stby_pkg::st_reset: begin
				// leave reset once released and counted
				if (reset_sync_n && fetch_ready && bus_hold_request_n) begin
					next_state = stby_pkg::st_run;
				end
			end
			stby_pkg::st_run: begin
				if (halt_exec) begin
					case (standby_sel)
						stby_pkg::sel_idle: next_state = stby_pkg::st_idle;
						stby_pkg::sel_stop: next_state = stby_pkg::st_stop;
						default: next_state = stby_pkg::st_halt;
					endcase
				end
			end
			stby_pkg::st_halt: begin
				if (wake_request) begin
					next_state = stby_pkg::st_run;
				end
			end
			stby_pkg::st_idle: begin
				if (wake_request) begin
					next_state = stby_pkg::st_run;
				end
			end
			stby_pkg::st_stop: begin
				if (wake_request) begin
					next_state = direct_mode ? stby_pkg::st_run : stby_pkg::st_settle;
				end
			end
			stby_pkg::st_settle: begin
				if (settle_done) begin
					next_state = stby_pkg::st_run;
				end
			end
			default: next_state = stby_pkg::st_reset;
		endcase
	end

	// any low reset level forces system reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= stby_pkg::st_reset;
		end else if (!reset_sync_n) begin
			state <= stby_pkg::st_reset;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// oscillation settling
	// ----------------------------------------
	assign settle_start = (state == stby_pkg::st_stop) && wake_request && !direct_mode;

	// counter restarts at zero on release
	settle_timer #(
		.WIDTH(stby_pkg::SETTLE_CNT_W),
		.COUNT(SETTLE_CYCLES)
	) u_settle (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.start(settle_start),
		.run(state == stby_pkg::st_settle),
		.done(settle_done)
	);

	assign wdt_clear = settle_start || (state == stby_pkg::st_reset);

	// settling time-out never reaches the pin
	// entry into reset or settling is masked too, so the pin is low from their first cycle
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			watchdog_timeout_out <= 1'b0;
		end else begin
			watchdog_timeout_out <= wdt_timeout_in && reset_sync_n
				&& (state != stby_pkg::st_reset) && (state != stby_pkg::st_settle)
				&& (next_state != stby_pkg::st_reset) && (next_state != stby_pkg::st_settle);
		end
	end

	// ----------------------------------------
	// clock gating
	// ----------------------------------------
	assign standby = (state == stby_pkg::st_halt) || (state == stby_pkg::st_idle)
		|| (state == stby_pkg::st_stop);
	assign system_reset = (state == stby_pkg::st_reset);
	assign osc_enable = !external_clk && (state != stby_pkg::st_stop);
	assign pll_enable = !direct_mode && (state != stby_pkg::st_stop);
	// cpu stopped in every standby mode
	assign cpu_clk_en = (state == stby_pkg::st_run);
	assign cpu_running = cpu_clk_en;
	assign periph_clk_en = (state == stby_pkg::st_run) || (state == stby_pkg::st_halt)
		|| system_reset;
	// gating only, no state is cleared on entry
	assign io_retain = standby || (state == stby_pkg::st_settle);

	// one fetch pulse on leaving reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fetch_start <= 1'b0;
		end else begin
			fetch_start <= system_reset && (next_state == stby_pkg::st_run);
		end
	end

	// ----------------------------------------
	// clock output
	// ----------------------------------------
	// toggles in reset, run, halt and idle unless disabled; high in stop and settling
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			system_clock_output_q <= 1'b1;
		end else if (system_clock_output_disable || state == stby_pkg::st_stop
			|| state == stby_pkg::st_settle) begin
			system_clock_output_q <= 1'b1;
		end else begin
			system_clock_output_q <= !system_clock_output_q;
		end
	end

	assign system_clock_output = system_clock_output_q;

	// ----------------------------------------
	// bus hold
	// ----------------------------------------
	// follows the request in reset, run and halt; held unchanged in idle, stop and settling
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bus_hold_grant_n <= 1'b1;
		end else if (state == stby_pkg::st_idle || state == stby_pkg::st_stop
			|| state == stby_pkg::st_settle) begin
			bus_hold_grant_n <= bus_hold_grant_n;
		end else begin
			bus_hold_grant_n <= bus_hold_request_n;
		end
	end

	assign bus_float = !bus_hold_grant_n;

	// ----------------------------------------
	// dram pins
	// ----------------------------------------
	// strobes high in reset and halt unless cbr runs
	always_comb begin
		self_refresh = (state == stby_pkg::st_idle) || (state == stby_pkg::st_stop)
			|| (state == stby_pkg::st_settle);
		if (strobe_idle(state) && !cbr_active) begin
			dram_ras_n = 1'b1;
			dram_lower_column_strobe_n = 1'b1;
			dram_upper_column_strobe_n = 1'b1;
			dram_refresh_request_n = 1'b1;
		end else begin
			dram_ras_n = ctl_ras_n;
			dram_lower_column_strobe_n = ctl_dram_lower_column_strobe_n;
			dram_upper_column_strobe_n = ctl_dram_upper_column_strobe_n;
			dram_refresh_request_n = ctl_dram_refresh_request_n;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	sequence stop_wake_s;
		(state == stby_pkg::st_stop) && wake_request;
	endsequence

	sequence idle_wake_s;
		(state == stby_pkg::st_idle) && wake_request && reset_sync_n;
	endsequence

	a_stop_clocks_off: assert property (
		(state == stby_pkg::st_stop) |-> !osc_enable && !pll_enable && !cpu_clk_en
			&& !periph_clk_en) else $error("clock active in stop");

	a_pll_stop_settle: assert property (
		stop_wake_s ##0 !direct_mode ##0 reset_sync_n |=> (state == stby_pkg::st_settle)
			&& !cpu_clk_en) else $error("pll stop release skipped settling");

	a_direct_stop_fast: assert property (
		stop_wake_s ##0 direct_mode ##0 reset_sync_n |=> cpu_clk_en)
		else $error("direct stop release waited");

	a_halt_gating: assert property (
		(state == stby_pkg::st_halt) |-> !cpu_clk_en && periph_clk_en
			&& (pll_enable == !direct_mode)) else $error("halt gating wrong");

	a_idle_no_hold: assert property (
		(state == stby_pkg::st_idle) && $stable(state) |-> $stable(bus_hold_grant_n))
		else $error("hold serviced in idle");

	a_halt_strobes: assert property (
		(state == stby_pkg::st_halt) && !cbr_active |-> dram_ras_n
			&& dram_lower_column_strobe_n && dram_upper_column_strobe_n
			&& dram_refresh_request_n) else $error("dram strobe low in halt");

	a_system_clock_output_parked: assert property (
		system_clock_output_disable |=> system_clock_output) else $error("disabled clock output not high");

	a_reset_pins: assert property (
		system_reset && !cbr_active |-> dram_ras_n && !cpu_clk_en && !watchdog_timeout_out)
		else $error("pin left reset state");

	a_fetch_delay: assert property (
		fetch_start |-> $past(fetch_ready) && $past(bus_hold_request_n))
		else $error("fetch started early");

	a_hold_in_reset: assert property (
		system_reset && !bus_hold_request_n |=> !bus_hold_grant_n && bus_float)
		else $error("hold not granted in reset");

	a_system_clock_output_reset: assert property (
		system_reset && !system_clock_output_disable ##1 system_reset && !system_clock_output_disable
			|=> system_clock_output != $past(system_clock_output))
		else $error("clock output stalled in reset");

	a_idle_fast: assert property (
		idle_wake_s |=> (state == stby_pkg::st_run)) else $error("idle release slow");

	a_settle_quiet: assert property (
		(state == stby_pkg::st_settle) |=> !watchdog_timeout_out)
		else $error("watchdog pin during settling");

endmodule : standby_reset_control

//--- testbench/hold_master.sv
`timescale 1ns/1ps
module hold_master (
	// clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// command from the bench
	input wire logic want_hold,
	input wire logic want_cbr,
	// pins toward the device
	output logic bus_hold_request_n,
	output logic ctl_ras_n,
	output logic ctl_dram_lower_column_strobe_n,
	output logic ctl_dram_upper_column_strobe_n,
	output logic ctl_dram_refresh_request_n,
	output logic cbr_active
);
	logic [3:0] phase;

	// quiet at power-on, may request later
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bus_hold_request_n <= 1'b1;
			phase <= 4'h0;
		end else begin
			bus_hold_request_n <= !want_hold;
			phase <= phase + 4'h1;
		end
	end

	// strobes keep moving so a leak through the gating shows
	assign ctl_ras_n = phase[0];
	assign ctl_dram_lower_column_strobe_n = phase[1];
	assign ctl_dram_upper_column_strobe_n = !phase[0];
	assign ctl_dram_refresh_request_n = phase[2];
	// refresh window on command, so the pass-through path is seen
	assign cbr_active = want_cbr;
endmodule : hold_master

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic sys_clk, nrst, reset_pin_n, halt_exec, wake_request, system_clock_output_disable, want_hold;
	logic want_cbr;
	logic [1:0] standby_sel, clk_source;
	logic wdt_timeout_in, system_reset, fetch_start, cpu_running, osc_enable, pll_enable;
	logic cpu_clk_en, periph_clk_en, io_retain, system_clock_output, bus_hold_request_n;
	logic bus_hold_grant_n, bus_float, ctl_ras_n, ctl_dram_lower_column_strobe_n, ctl_dram_upper_column_strobe_n, ctl_dram_refresh_request_n;
	logic cbr_active, dram_ras_n, dram_lower_column_strobe_n, dram_upper_column_strobe_n;
	logic dram_refresh_request_n, self_refresh, wdt_clear, watchdog_timeout_out;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;

	standby_reset_control #(.SETTLE_CYCLES(20)) standby_reset_control_i (.sys_clk, .nrst,
		.reset_pin_n, .halt_exec, .standby_sel, .clk_source, .wake_request, .system_clock_output_disable,
		.system_reset, .fetch_start, .cpu_running, .osc_enable, .pll_enable, .cpu_clk_en,
		.periph_clk_en, .io_retain, .system_clock_output, .bus_hold_request_n,
		.bus_hold_grant_n, .bus_float, .ctl_ras_n, .ctl_dram_lower_column_strobe_n, .ctl_dram_upper_column_strobe_n, .ctl_dram_refresh_request_n,
		.cbr_active, .dram_ras_n, .dram_lower_column_strobe_n, .dram_upper_column_strobe_n,
		.dram_refresh_request_n, .self_refresh, .wdt_timeout_in, .wdt_clear,
		.watchdog_timeout_out);

	hold_master hold_master_i (.sys_clk, .nrst, .want_hold, .want_cbr, .bus_hold_request_n,
		.ctl_ras_n,
		.ctl_dram_lower_column_strobe_n, .ctl_dram_upper_column_strobe_n, .ctl_dram_refresh_request_n, .cbr_active);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// compare and close
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic check_bit(input logic got, input logic exp);
		check({7'h00, got}, {7'h00, exp});
	endtask : check_bit

	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	// ceiling well above the ten standby passes plus two boots
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			close_out();
		end
	end

	task automatic wait_fetch(output int n);
		n = 0;
		while (fetch_start !== 1'b1 && n < 60) begin
			@(negedge sys_clk);
			n++;
		end
	endtask : wait_fetch

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_boot();
		int n;
		logic c0;
		@(negedge sys_clk);
		check({system_reset, bus_hold_grant_n, watchdog_timeout_out, fetch_start}, 8'h0C);
		check({dram_ras_n, dram_lower_column_strobe_n, dram_upper_column_strobe_n,
			dram_refresh_request_n}, 8'h0F);
		c0 = system_clock_output;
		@(negedge sys_clk);
		check_bit(system_clock_output, !c0);
		wait_fetch(n);
		check_bit(n >= 28 && n <= 34, 1'b1);
		@(negedge sys_clk);
		check({system_reset, cpu_running}, 8'h01);
		$display("test boot done");
	endtask : t_boot

	task automatic t_hold_in_reset();
		int n;
		logic saw;
		saw = 1'b0;
		@(posedge sys_clk);
		reset_pin_n <= 1'b0;
		want_hold <= 1'b1;
		repeat (6) @(negedge sys_clk);
		check({system_reset, bus_hold_grant_n, bus_float}, 8'h05);
		@(posedge sys_clk);
		reset_pin_n <= 1'b1;
		repeat (45) begin
			@(negedge sys_clk);
			saw = saw | fetch_start;
		end
		check_bit(saw, 1'b0);
		@(posedge sys_clk);
		want_hold <= 1'b0;
		wait_fetch(n);
		check_bit(n < 10, 1'b1);
		$display("test hold in reset done");
	endtask : t_hold_in_reset

	task automatic t_standby(input logic [1:0] sel, input logic [1:0] src);
		int n;
		logic c0, halt, stop, settle, saw;
		// code 3 is decoded as halt
		halt = (sel != stby_pkg::sel_idle) && (sel != stby_pkg::sel_stop);
		stop = (sel == stby_pkg::sel_stop);
		settle = stop && src != stby_pkg::src_direct;
		saw = 1'b0;
		@(posedge sys_clk);
		standby_sel <= sel;
		clk_source <= src;
		halt_exec <= 1'b1;
		@(posedge sys_clk);
		halt_exec <= 1'b0;
		@(negedge sys_clk);
		check({osc_enable, pll_enable, cpu_clk_en, periph_clk_en, io_retain, self_refresh,
			cpu_running}, {1'b0, src == stby_pkg::src_resonator && !stop,
			src != stby_pkg::src_direct && !stop, 1'b0, halt, 1'b1, !halt, 1'b0});
		if (halt) begin
			check({dram_ras_n, dram_lower_column_strobe_n, dram_upper_column_strobe_n,
				dram_refresh_request_n}, 8'h0F);
			@(posedge sys_clk);
			want_cbr <= 1'b1;
			@(negedge sys_clk);
			check({dram_ras_n, dram_lower_column_strobe_n, dram_upper_column_strobe_n,
				dram_refresh_request_n}, {ctl_ras_n, ctl_dram_lower_column_strobe_n, ctl_dram_upper_column_strobe_n, ctl_dram_refresh_request_n});
			@(posedge sys_clk);
			want_cbr <= 1'b0;
			@(negedge sys_clk);
		end
		c0 = system_clock_output;
		@(negedge sys_clk);
		check_bit(system_clock_output, (stop || system_clock_output_disable) ? 1'b1 : !c0);
		@(posedge sys_clk);
		want_hold <= 1'b1;
		repeat (4) @(negedge sys_clk);
		check_bit(bus_hold_grant_n, !halt);
		@(posedge sys_clk);
		want_hold <= 1'b0;
		repeat (4) @(posedge sys_clk);
		wake_request <= 1'b1;
		wdt_timeout_in <= settle;
		@(posedge sys_clk);
		wake_request <= 1'b0;
		@(negedge sys_clk);
		check_bit(watchdog_timeout_out, 1'b0);
		n = 0;
		while (cpu_running !== 1'b1 && n < 100) begin
			@(negedge sys_clk);
			saw = saw | watchdog_timeout_out;
			n++;
		end
		check_bit(settle ? (n >= 19 && n <= 22) : (n == 0), 1'b1);
		check_bit(saw, 1'b0);
		// time-out reaches the pin once settling is over
		@(negedge sys_clk);
		check_bit(watchdog_timeout_out, settle);
		@(posedge sys_clk);
		wdt_timeout_in <= 1'b0;
		$display("test standby sel %0d src %0d done", sel, src);
	endtask : t_standby

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		reset_pin_n = 1'b1;
		halt_exec = 1'b0;
		wake_request = 1'b0;
		system_clock_output_disable = 1'b0;
		want_hold = 1'b0;
		want_cbr = 1'b0;
		standby_sel = 2'h0;
		clk_source = 2'h0;
		wdt_timeout_in = 1'b0;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		t_boot();
		t_hold_in_reset();
		for (int s = 0; s < 3; s++) begin
			for (int c = 0; c < 3; c++) begin
				t_standby(2'(s), 2'(c));
			end
		end
		@(posedge sys_clk);
		system_clock_output_disable <= 1'b1;
		t_standby(2'h3, 2'h0);
		close_out();
	end
endmodule : testbench
